//--- common/rbt_regs.svh
`ifndef RBT_REGS_SVH
`define RBT_REGS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RBT_OFS_COUNT   12'h000
`define RBT_OFS_CTRL    12'h004
`define RBT_OFS_FLAGS   12'h008
`define RBT_OFS_PWRCLK  12'h00C
`define RBT_OFS_CSR     12'h010
`define RBT_OFS_SEQ     12'h014
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define RBT_CTRL_DATA   0
`define RBT_CTRL_FULL   1
`define RBT_CTRL_MODE_L 2
`define RBT_CTRL_EN0    4
`define RBT_CTRL_EN2    5
`define RBT_CTRL_HI_L   6
`define RBT_FLAG0       0
`define RBT_FLAG2       2
`define RBT_CSR_GIE     7
// ----------------------------------------------------------------
// Modes, vectors, reset values, timing
// ----------------------------------------------------------------
`define RBT_MODE_OFF    2'h0
`define RBT_MODE_TX     2'h1
`define RBT_MODE_RX     2'h2
`define RBT_MODE_GEN    2'h3
`define RBT_VEC_RESET   10'h000
`define RBT_VEC_DONE    10'h002
`define RBT_VEC_EMPTY   10'h004
`define RBT_RST_BYTE    8'h00
`define RBT_ENTRY_CYC   3'h4
`define RBT_JUMP_CYC    3'h2
`define RBT_RET_CYC     3'h4
`endif

//--- common/rbt_pkg.sv
package rbt_pkg;
    typedef enum logic [2:0] {
        RBT_SEQ_IDLE,
        RBT_SEQ_ENTRY,
        RBT_SEQ_JUMP,
        RBT_SEQ_HANDLER,
        RBT_SEQ_RETURN,
        RBT_SEQ_ONE_MORE
    } rbt_seq_t;
    typedef logic [9:0] rbt_vec_t;
endpackage

//--- hw/rbt_bit_timer.sv
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "rbt_regs.svh"
// Notes on behaviour
// - Slot lasts time base times count plus one
// - Count is control top bits over count
// - Time base set by power clock control
// - Taking data bit sets flag 0, vector 04
// - Zero with empty buffer sets flag 2
// - Transmit keys carrier per slot data bit
// - Flags set regardless of interrupt enables
// - Receive counts up, edge captures count
// - Receive edge polarity writes data bit
// - Generic mode no keying, interrupt on expiry
// - No interrupt without global enable bit
// - Pin, watchdog, button reset vector 000
// - Entry four cycles pushing program counter
// - Vector jump takes two cycles
// - Finish multi-cycle instruction before serving
// - Return four cycles popping program counter
// - One main instruction after return
// - Status register not saved on entry
// - Carrier gated by keying before amplifier
module rbt_bit_timer (
    // APB
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    // RF path
    input  wire logic           carrier_in,
    output logic                tx_key,
    output logic                pa_drive,
    // Receiver input
    input  wire logic           capture_input_pin,
    // Core handshake
    input  wire logic           core_insn_done,
    input  wire logic           core_reti,
    input  wire logic           pin_reset_req,
    input  wire logic           wdt_reset_req,
    input  wire logic           button_reset_req,
    output rbt_pkg::rbt_vec_t   core_vector_addr,
    output logic                core_vector_load,
    output logic                core_pc_push,
    output logic                core_pc_pop
);
    import rbt_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] bit_count_low_reg;
    logic [7:0] bit_timer_control_reg;
    logic [7:0] flags_reg;
    logic [7:0] power_clock_control_reg;
    logic [7:0] core_status_register_reg;
    logic [7:0] pre_cnt_reg;
    logic [9:0] cnt_reg;
    logic       run_reg;
    logic [2:0] cap_sync_reg;
    logic [2:0] rst_sync1_reg;
    logic [2:0] rst_sync2_reg;
    logic       rst_seen_reg;
    rbt_seq_t   seq_reg;
    logic [2:0] seq_cnt_reg;
    logic       gen_done_reg;

    logic       wr_en;
    logic       tick;
    logic [1:0] mode;
    logic [9:0] countval;
    logic       take0;
    logic       set0;
    logic       set2;
    logic       cap_edge;
    logic       rst_any;
    logic       irq0;
    logic       irq2;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr_en    = psel && penable && pready && pwrite;
    assign mode     = bit_timer_control_reg[`RBT_CTRL_MODE_L +: 2];
    assign countval = {bit_timer_control_reg[`RBT_CTRL_HI_L +: 2], bit_count_low_reg};
    assign tick     = (pre_cnt_reg == power_clock_control_reg);
    assign cap_edge = cap_sync_reg[2] ^ cap_sync_reg[1];
    assign rst_any  = |rst_sync2_reg;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // No wait state: prdata and pready, loaded in the setup cycle, come straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel && !penable) begin
                if (hit(paddr, `RBT_OFS_COUNT))
                    prdata <= {24'h000000, bit_count_low_reg};
                else if (hit(paddr, `RBT_OFS_CTRL))
                    prdata <= {24'h000000, bit_timer_control_reg};
                else if (hit(paddr, `RBT_OFS_FLAGS))
                    prdata <= {24'h000000, flags_reg};
                else if (hit(paddr, `RBT_OFS_PWRCLK))
                    prdata <= {24'h000000, power_clock_control_reg};
                else if (hit(paddr, `RBT_OFS_CSR))
                    prdata <= {24'h000000, core_status_register_reg};
                else if (hit(paddr, `RBT_OFS_SEQ))
                    prdata <= {19'h00000, seq_reg, core_vector_addr};
                else
                    pslverr <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Time base prescaler
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pre_cnt_reg <= `RBT_RST_BYTE;
        else if (tick || mode == `RBT_MODE_OFF)
            pre_cnt_reg <= `RBT_RST_BYTE;
        else
            pre_cnt_reg <= pre_cnt_reg + 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            power_clock_control_reg <= `RBT_RST_BYTE;
        else if (wr_en && hit(paddr, `RBT_OFS_PWRCLK))
            power_clock_control_reg <= pwdata[7:0];
    end

    // ----------------------------------------------------------------
    // Capture input synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cap_sync_reg <= 3'h0;
        else
            cap_sync_reg <= {cap_sync_reg[1:0], capture_input_pin};
    end

    // ----------------------------------------------------------------
    // Slot counter
    // ----------------------------------------------------------------
    // Buffer taken at slot start or at the end of the last slot
    assign take0 = (mode == `RBT_MODE_TX) && bit_timer_control_reg[`RBT_CTRL_FULL]
                   && tick && (!run_reg || cnt_reg == 10'h000);
    assign set0  = take0;
    assign set2  = (((mode == `RBT_MODE_TX) && run_reg && !bit_timer_control_reg[`RBT_CTRL_FULL])
                   || ((mode == `RBT_MODE_GEN) && !gen_done_reg))
                   && tick && cnt_reg == 10'h000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg      <= 10'h000;
            run_reg      <= 1'b0;
            gen_done_reg <= 1'b0;
        end else if (mode == `RBT_MODE_TX) begin
            gen_done_reg <= 1'b0;
            if (take0) begin
                cnt_reg <= countval;
                run_reg <= 1'b1;
            end else if (set2) begin
                run_reg <= 1'b0;
            end else if (tick && run_reg) begin
                cnt_reg <= cnt_reg - 10'h001;
            end
        end else if (mode == `RBT_MODE_RX) begin
            run_reg      <= 1'b1;
            gen_done_reg <= 1'b0;
            if (!run_reg)
                cnt_reg <= 10'h000;
            else if (tick)
                cnt_reg <= cnt_reg + 10'h001;
        end else if (mode == `RBT_MODE_GEN) begin
            if (!run_reg) begin
                cnt_reg <= countval;
                run_reg <= 1'b1;
            end else if (set2) begin
                gen_done_reg <= 1'b1;
            end else if (tick && !gen_done_reg) begin
                cnt_reg <= cnt_reg - 10'h001;
            end
        end else begin
            run_reg      <= 1'b0;
            gen_done_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Count and control registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            bit_count_low_reg <= `RBT_RST_BYTE;
        else if (mode == `RBT_MODE_RX && run_reg && cap_edge)
            bit_count_low_reg <= cnt_reg[7:0];
        else if (wr_en && hit(paddr, `RBT_OFS_COUNT))
            bit_count_low_reg <= pwdata[7:0];
    end

    // A software refill wins over a hardware take in the same cycle: FULL stays set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_timer_control_reg <= `RBT_RST_BYTE;
        end else begin
            if (wr_en && hit(paddr, `RBT_OFS_CTRL)) begin
                bit_timer_control_reg[7:2]            <= pwdata[7:2];
                bit_timer_control_reg[`RBT_CTRL_DATA] <= pwdata[`RBT_CTRL_DATA];
                bit_timer_control_reg[`RBT_CTRL_FULL] <= 1'b1;
            end else if (take0) begin
                bit_timer_control_reg[`RBT_CTRL_FULL] <= 1'b0;
            end
            if (mode == `RBT_MODE_RX && run_reg && cap_edge)
                bit_timer_control_reg[`RBT_CTRL_DATA] <= cap_sync_reg[1];
        end
    end

    // ----------------------------------------------------------------
    // Flags, set wins over write-one clear
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= `RBT_RST_BYTE;
        end else begin
            if (wr_en && hit(paddr, `RBT_OFS_FLAGS))
                flags_reg <= flags_reg & ~pwdata[7:0];
            if (set0)
                flags_reg[`RBT_FLAG0] <= 1'b1;
            if (set2)
                flags_reg[`RBT_FLAG2] <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Keying and amplifier gate
    // ----------------------------------------------------------------
    // The carrier is resampled on pclk, so it must be far slower than pclk here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_key   <= 1'b0;
            pa_drive <= 1'b0;
        end else begin
            if (mode != `RBT_MODE_TX || set2)
                tx_key <= 1'b0;
            else if (take0)
                tx_key <= bit_timer_control_reg[`RBT_CTRL_DATA];
            pa_drive <= carrier_in && tx_key;
        end
    end

    // ----------------------------------------------------------------
    // Core status and reset sources
    // ----------------------------------------------------------------
    // Never written by the sequencer: the handler saves it itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            core_status_register_reg <= `RBT_RST_BYTE;
        else if (wr_en && hit(paddr, `RBT_OFS_CSR))
            core_status_register_reg <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_sync1_reg <= 3'h0;
            rst_sync2_reg <= 3'h0;
            rst_seen_reg  <= 1'b0;
        end else begin
            rst_sync1_reg <= {button_reset_req, wdt_reset_req, pin_reset_req};
            rst_sync2_reg <= rst_sync1_reg;
            rst_seen_reg  <= rst_any;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt sequencer
    // ----------------------------------------------------------------
    assign irq2 = flags_reg[`RBT_FLAG2] && bit_timer_control_reg[`RBT_CTRL_EN2]
                  && core_status_register_reg[`RBT_CSR_GIE];
    assign irq0 = flags_reg[`RBT_FLAG0] && bit_timer_control_reg[`RBT_CTRL_EN0]
                  && core_status_register_reg[`RBT_CSR_GIE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_reg          <= RBT_SEQ_IDLE;
            seq_cnt_reg      <= 3'h0;
            core_vector_addr <= `RBT_VEC_RESET;
            core_vector_load <= 1'b0;
            core_pc_push     <= 1'b0;
            core_pc_pop      <= 1'b0;
        end else if (rst_any && !rst_seen_reg) begin
            seq_reg          <= RBT_SEQ_IDLE;
            core_vector_addr <= `RBT_VEC_RESET;
            core_vector_load <= 1'b1;
            core_pc_push     <= 1'b0;
            core_pc_pop      <= 1'b0;
        end else begin
            core_vector_load <= 1'b0;
            core_pc_push     <= 1'b0;
            core_pc_pop      <= 1'b0;
            case (seq_reg)
                RBT_SEQ_IDLE: begin
                    if (core_insn_done && (irq0 || irq2)) begin
                        seq_reg          <= RBT_SEQ_ENTRY;
                        seq_cnt_reg      <= `RBT_ENTRY_CYC - 3'h1;
                        core_vector_addr <= irq2 ? `RBT_VEC_DONE : `RBT_VEC_EMPTY;
                        core_pc_push     <= 1'b1;
                    end
                end
                RBT_SEQ_ENTRY: begin
                    if (seq_cnt_reg == 3'h1) begin
                        seq_reg          <= RBT_SEQ_JUMP;
                        seq_cnt_reg      <= `RBT_JUMP_CYC;
                        core_vector_load <= 1'b1;
                    end else begin
                        seq_cnt_reg <= seq_cnt_reg - 3'h1;
                    end
                end
                RBT_SEQ_JUMP: begin
                    if (seq_cnt_reg == 3'h1)
                        seq_reg <= RBT_SEQ_HANDLER;
                    seq_cnt_reg <= seq_cnt_reg - 3'h1;
                end
                RBT_SEQ_HANDLER: begin
                    if (core_reti) begin
                        seq_reg     <= RBT_SEQ_RETURN;
                        seq_cnt_reg <= `RBT_RET_CYC - 3'h1;
                        core_pc_pop <= 1'b1;
                    end
                end
                RBT_SEQ_RETURN: begin
                    if (seq_cnt_reg == 3'h1)
                        seq_reg <= RBT_SEQ_ONE_MORE;
                    seq_cnt_reg <= seq_cnt_reg - 3'h1;
                end
                RBT_SEQ_ONE_MORE: begin
                    if (core_insn_done)
                        seq_reg <= RBT_SEQ_IDLE;
                end
                default: begin
                    seq_reg <= RBT_SEQ_IDLE;
                end
            endcase
        end
    end
endmodule

//--- dv/rbt_rf_model.sv
`timescale 1ns/10ps
module rbt_rf_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Receiver chip side
    input  wire logic rx_level,
    output logic      capture_input_pin,
    // Synthesizer side
    output logic      carrier_in
);
    logic [3:0] div_reg;
    // ----------------------------------------
    // Carrier runs free, slow against pclk so gating shows
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) div_reg <= 4'h0;
        else div_reg <= div_reg + 4'h1;
    end
    assign carrier_in = div_reg[3];
    // Receiver output is a driven level, never released
    assign capture_input_pin = rx_level;
endmodule

//--- dv/rbt_bit_timer_monitor.sv
`timescale 1ns/10ps
`include "rbt_regs.svh"
module rbt_bit_timer_monitor (
    // APB
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // RF path
    input wire logic              carrier_in,
    input wire logic              tx_key,
    input wire logic              pa_drive,
    // Core handshake
    input wire logic              core_insn_done,
    input wire logic              core_pc_push,
    input wire logic              core_pc_pop,
    input wire logic              core_vector_load,
    input wire rbt_pkg::rbt_vec_t core_vector_addr
);
    import rbt_pkg::*;
    logic [1:0] mode_q;
    logic       gie_q;
    // ----------------------------------------
    // Shadow of mode and global enable, seen from bus writes
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `RBT_MODE_OFF;
            gie_q  <= 1'b0;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == `RBT_OFS_CTRL) mode_q <= pwdata[3:2];
            if (paddr == `RBT_OFS_CSR) gie_q <= pwdata[`RBT_CSR_GIE];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("pready not a one-cycle access answer");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready or with data");
    property p_gate; pa_drive == $past(carrier_in && tx_key); endproperty
    a_gate: assert property (p_gate) else $error("amplifier drive not gated by key");
    property p_vec;
        core_vector_load |-> core_vector_addr inside {`RBT_VEC_DONE, `RBT_VEC_EMPTY, `RBT_VEC_RESET};
    endproperty
    a_vec: assert property (p_vec) else $error("vector outside table");
    // Push cycle plus three more, the vector load lands in the fourth
    property p_entry; core_pc_push |=> !core_vector_load [*2] ##1 core_vector_load; endproperty
    a_entry: assert property (p_entry) else $error("entry length wrong");
    property p_ret; core_pc_pop |=> !core_pc_push [*4]; endproperty
    a_ret: assert property (p_ret) else $error("push during return");
    property p_cause; core_pc_push |-> $past(core_insn_done) && gie_q; endproperty
    a_cause: assert property (p_cause) else $error("entry without boundary or enable");
    property p_nokey; (mode_q != `RBT_MODE_TX) [*3] |-> !tx_key; endproperty
    a_nokey: assert property (p_nokey) else $error("key outside transmit mode");
    c_done: cover property (core_vector_load && core_vector_addr == `RBT_VEC_DONE);
    c_err: cover property (pslverr);
    c_pop: cover property (core_pc_pop);
    c_key: cover property ($rose(tx_key));
endmodule
bind rbt_bit_timer rbt_bit_timer_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .carrier_in(carrier_in), .tx_key(tx_key), .pa_drive(pa_drive), .core_insn_done(core_insn_done),
    .core_pc_push(core_pc_push), .core_pc_pop(core_pc_pop), .core_vector_load(core_vector_load),
    .core_vector_addr(core_vector_addr)
);

//--- dv/rbt_bit_timer_test.sv
`timescale 1ns/10ps
`include "rbt_regs.svh"
module rbt_bit_timer_test;
    import rbt_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic x;} rbt_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        carrier_in, tx_key, pa_drive, capture_input_pin, rx_level;
    logic        core_insn_done, core_reti, core_run, core_vector_load, core_pc_push, core_pc_pop;
    logic [2:0]  rst_req;
    logic [7:0]  c1;
    rbt_vec_t    core_vector_addr;
    int          failures, total_checks, pushes, pops, n;
    time         t_rise, t_fall;
    rbt_row_t    rows [6] = '{'{`RBT_OFS_COUNT, 32'h1A5, 32'hA5, 1'b0}, '{`RBT_OFS_PWRCLK, 32'h3, 32'h3, 1'b0},
        '{`RBT_OFS_CSR, 32'h80, 32'h80, 1'b0}, '{`RBT_OFS_CSR, 32'h0, 32'h0, 1'b0},
        '{`RBT_OFS_SEQ, 32'h3FF, 32'h0, 1'b0}, '{12'h020, 32'hFF, 32'h0, 1'b1}};
    rbt_bit_timer u_rbt_bit_timer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .carrier_in(carrier_in), .tx_key(tx_key), .pa_drive(pa_drive),
        .capture_input_pin(capture_input_pin), .core_insn_done(core_insn_done), .core_reti(core_reti),
        .pin_reset_req(rst_req[0]), .wdt_reset_req(rst_req[1]), .button_reset_req(rst_req[2]),
        .core_vector_addr(core_vector_addr), .core_vector_load(core_vector_load),
        .core_pc_push(core_pc_push), .core_pc_pop(core_pc_pop));
    rbt_rf_model u_rbt_rf_model (.pclk(pclk), .presetn(presetn), .rx_level(rx_level),
        .capture_input_pin(capture_input_pin), .carrier_in(carrier_in));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Simple core: an instruction boundary every other cycle while running
    always @(posedge pclk) core_insn_done <= core_run && !core_insn_done;
    always @(posedge pclk) begin
        if (core_pc_push === 1'b1) pushes++;
        if (core_pc_pop === 1'b1) pops++;
    end
    always @(posedge tx_key) t_rise = $time;
    always @(negedge tx_key) t_fall = $time;
    task automatic close_out;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
        total_checks++;
        if (s !== e) begin
            $display("FAIL %0t %s", $time, m);
            failures++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) failures++;
        if (i == 20) close_out();
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e, "read data");
    endtask
    // Waits for a level; a used-up bound ends the run as a mismatch
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        for (n = 0; n < lim && s !== v; n++) @(posedge pclk);
        if (n == lim) failures++;
        if (n == lim) close_out();
    endtask
    task automatic reti;
        @(posedge pclk) core_reti <= 1'b1;
        @(posedge pclk) core_reti <= 1'b0;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, core_reti, core_run, rst_req, rx_level} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        core_run <= 1'b1;
        for (int k = 0; k < 6; k++) rchk(12'(k * 4), {24'h0, `RBT_RST_BYTE});
        foreach (rows[k]) begin
            apb(1'b1, rows[k].a, rows[k].d);
            rchk(rows[k].a, rows[k].e);
            chk(err, rows[k].x, "slave error");
        end
        $display("test registers done");
        // Transmit: two bits, slot of (0x102+1) ticks, tick every 2 clocks
        apb(1'b1, `RBT_OFS_COUNT, 32'h02);
        apb(1'b1, `RBT_OFS_PWRCLK, 32'h01);
        apb(1'b1, `RBT_OFS_CTRL, 32'h75);
        wait_lvl(tx_key, 1'b1, 100);
        rchk(`RBT_OFS_FLAGS, 32'h1);
        apb(1'b1, `RBT_OFS_CTRL, 32'h74);
        wait_lvl(tx_key, 1'b0, 1000);
        chk(32'(t_fall - t_rise), 2 * (32'h102 + 1) * 5, "slot length");
        repeat (530) @(posedge pclk);
        rchk(`RBT_OFS_FLAGS, 32'h5);
        chk(tx_key, 1'b0, "key after done");
        chk(pushes, 0, "entry with enable off");
        apb(1'b1, `RBT_OFS_CTRL, 32'h0);
        apb(1'b1, `RBT_OFS_FLAGS, 32'h5);
        $display("test transmit done");
        // Generic one-shot with interrupts through the sequencer
        apb(1'b1, `RBT_OFS_PWRCLK, 32'h0);
        apb(1'b1, `RBT_OFS_COUNT, 32'h3);
        apb(1'b1, `RBT_OFS_CSR, 32'h80);
        apb(1'b1, `RBT_OFS_CTRL, 32'h2C);
        wait_lvl(core_vector_load, 1'b1, 200);
        chk(core_vector_addr, `RBT_VEC_DONE, "vector");
        chk(pushes, 1, "one entry");
        rchk(`RBT_OFS_SEQ, {19'h0, RBT_SEQ_HANDLER, `RBT_VEC_DONE});
        rchk(`RBT_OFS_CSR, 32'h80);
        core_run <= 1'b0;
        reti();
        repeat (12) @(posedge pclk);
        chk(pops, 1, "one return");
        chk(pushes, 1, "pending served too early");
        rchk(`RBT_OFS_SEQ, {19'h0, RBT_SEQ_ONE_MORE, `RBT_VEC_DONE});
        core_run <= 1'b1;
        wait_lvl(core_pc_push, 1'b1, 50);
        apb(1'b1, `RBT_OFS_FLAGS, 32'h5);
        apb(1'b1, `RBT_OFS_CTRL, 32'h0);
        reti();
        $display("test interrupt done");
        // Receive: two edges 40 clocks apart, one tick per clock
        apb(1'b1, `RBT_OFS_CTRL, 32'h08);
        repeat (20) @(posedge pclk);
        fork
            begin
                rx_level <= 1'b1;
                repeat (40) @(posedge pclk);
                rx_level <= 1'b0;
            end
            begin
                repeat (8) @(posedge pclk);
                apb(1'b0, `RBT_OFS_COUNT, 32'h0);
                c1 = rd[7:0];
                apb(1'b0, `RBT_OFS_CTRL, 32'h0);
                chk(rd[0], 1'b1, "rising edge level");
                chk(c1 < 8'd40, 1'b1, "count from zero");
            end
        join
        repeat (8) @(posedge pclk);
        apb(1'b0, `RBT_OFS_COUNT, 32'h0);
        chk(rd[7:0] - c1, 8'd40, "edge spacing");
        apb(1'b0, `RBT_OFS_CTRL, 32'h0);
        chk(rd[0], 1'b0, "falling edge level");
        apb(1'b1, `RBT_OFS_CTRL, 32'h0);
        $display("test receive done");
        for (int k = 0; k < 3; k++) begin
            rst_req[k] <= 1'b1;
            wait_lvl(core_vector_load, 1'b1, 8);
            chk(core_vector_addr, `RBT_VEC_RESET, "reset vector");
            rst_req[k] <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        apb(1'b1, `RBT_OFS_COUNT, 32'h77);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({tx_key, pready, core_vector_addr}, 32'h0, "outputs in reset");
        presetn <= 1'b1;
        rchk(`RBT_OFS_COUNT, 32'h0);
        $display("test reset done");
        close_out();
    end
endmodule
